//--- bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`include "meter_irq_cfg.svh"

module tb_top;
  logic clk, srst, hsel, hwrite, hready, hreadyout, hresp, irq_n;
  logic [31:0] haddr, hwdata, hrdata, crc_now;
  logic [1:0] htrans;
  logic [2:0] hsize, tot_act_b30, fund_act_b30, fund_var_b30, apparent_b30;
  logic [2:0] tot_act_neg, fund_act_neg, fund_var_neg, pulse_raw_n;
  logic [2:0] pulse_pin_n, src1, src2, src3;
  logic line_mode_on, line_cycle_end, path1_sum_neg, path2_sum_neg;
  logic dsp_cycle_end, volt_peak_end, run_set, crc_valid, sign_sel;
  logic rd_ph = 1'b0;
  logic pin_dis;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  int bad_count, tests_run;

  assign hready = hreadyout;

  meter_irq_status_mask u_meter_irq_status_mask (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tot_act_b30(tot_act_b30), .fund_act_b30(fund_act_b30),
    .fund_var_b30(fund_var_b30), .apparent_b30(apparent_b30),
    .line_mode_on(line_mode_on), .line_cycle_end(line_cycle_end),
    .tot_act_neg(tot_act_neg), .fund_act_neg(fund_act_neg),
    .path1_sum_neg(path1_sum_neg), .path2_sum_neg(path2_sum_neg),
    .fund_var_neg(fund_var_neg), .pulse_raw_n(pulse_raw_n),
    .dsp_cycle_end(dsp_cycle_end), .volt_peak_end(volt_peak_end),
    .run_set(run_set), .crc_now(crc_now), .crc_valid(crc_valid),
    .irq_n(irq_n), .pulse_pin_n(pulse_pin_n), .pulse_1_source(src1),
    .pulse_2_source(src2), .pulse_3_source(src3),
    .power_sign_source_sel(sign_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Read data is compared at the edge that ends the read data phase
  always @(posedge clk) begin
    if (hreadyout) begin
      if (rd_ph) begin
        check(hresp, 32'h0000_0000);
        if (exp_q.size() == 0) check(hrdata, 32'hdead_beef);
        else check(hrdata, exp_q.pop_front());
      end
      rd_ph <= hsel && htrans[1] && !hwrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    haddr <= {14'h0000, idx, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? d : 32'h0000_0000;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One event source for each flag bit of the first flag register
  task automatic cause(input int b);
    int ph;
    logic [2:0] pe;
    ph = $urandom_range(2, 0);
    @(posedge clk);
    case (b)
      0: tot_act_b30[ph] <= ~tot_act_b30[ph];
      1: fund_act_b30[ph] <= ~fund_act_b30[ph];
      3: fund_var_b30[ph] <= ~fund_var_b30[ph];
      4: apparent_b30[ph] <= ~apparent_b30[ph];
      5: line_cycle_end <= 1'b1;
      6, 7, 8: tot_act_neg[b-6] <= ~tot_act_neg[b-6];
      9: path1_sum_neg <= ~path1_sum_neg;
      10, 11, 12: fund_var_neg[b-10] <= ~fund_var_neg[b-10];
      13: path2_sum_neg <= ~path2_sum_neg;
      14, 15, 16: pulse_raw_n[b-14] <= 1'b0;
      default: dsp_cycle_end <= 1'b1;
    endcase
    @(posedge clk);
    line_cycle_end <= 1'b0;
    dsp_cycle_end <= 1'b0;
    if (b >= 14 && b <= 16) begin
      @(posedge clk);
      pe = pin_dis ? 3'b111 : ~(3'b001 << (b - 14));
      check(pulse_pin_n, pe);
      pulse_raw_n <= 3'b111;
    end
  endtask

  task automatic event_round(input int b);
    cause(b);
    cyc(3);
    check(irq_n, 1'b0);
    rd(`IDX_FLAGS_0, 32'h1 << b);
    wr(`IDX_FLAGS_0, 32'h1 << b);
    cyc(2);
    check(irq_n, 1'b1);
    rd(`IDX_FLAGS_0, 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; tot_act_b30 = '0; fund_act_b30 = '0;
    fund_var_b30 = '0; apparent_b30 = '0; line_mode_on = 1'b1;
    line_cycle_end = 1'b0; tot_act_neg = '0; fund_act_neg = '0;
    path1_sum_neg = 1'b0; path2_sum_neg = 1'b0; fund_var_neg = '0;
    pulse_raw_n = 3'b111; dsp_cycle_end = 1'b0; volt_peak_end = 1'b0;
    run_set = 1'b0; crc_now = '0; crc_valid = 1'b0;
    pin_dis = 1'b1; bad_count = 0; tests_run = 0;
    void'($urandom(32'hf2661164));
    cyc(20);
    srst <= 1'b0;
    cyc(2);
    check(irq_n, 1'b1);
    check(pulse_pin_n, 3'b111);
    rd(`IDX_ENABLE_0, `RST_ENABLE_0);
    rd(`IDX_FLAGS_0, `RST_FLAGS_0);
    rd(`IDX_FLAGS_1, 32'h0000_0000);
    rd(`IDX_PULSE_MODE, 32'h0000_0000);
    r = $urandom;
    wr(`IDX_ENABLE_0, r);
    rd(`IDX_ENABLE_0, r & `FLAGS_0_MASK);
    wr(16'hE605, 32'hFFFF_FFFF);
    rd(16'hE605, 32'h0000_0000);
    wr(`IDX_ENABLE_0, 32'hFFFF_FFFF);
    rd(`IDX_ENABLE_0, 32'h0003_FFFB);
    wr(`IDX_PULSE_MODE, 32'h0000_0E00);
    for (int b = 0; b < 18; b++)
      if (b != 2) event_round(b);
    // Flag is sticky, its interrupt is gated by its enable bit
    wr(`IDX_ENABLE_0, 32'h0000_0000);
    cause(17);
    cyc(3);
    check(irq_n, 1'b1);
    wr(`IDX_ENABLE_0, 32'h1 << 17);
    cyc(2);
    check(irq_n, 1'b0);
    wr(`IDX_FLAGS_0, 32'h1 << 17);
    wr(`IDX_ENABLE_0, 32'hFFFF_FFFF);
    // Line end outside line mode is not an event
    line_mode_on <= 1'b0;
    cause(5);
    cyc(3);
    rd(`IDX_FLAGS_0, 32'h0000_0000);
    // Fundamental power signs selected
    fund_act_neg <= tot_act_neg;
    cyc(2);
    wr(`IDX_ACC_MODE, 32'h1 << `BIT_SIGN_SRC_SEL);
    cyc(1);
    check(sign_sel, 1'b1);
    fund_act_neg[1] <= ~fund_act_neg[1];
    tot_act_neg[0] <= ~tot_act_neg[0];
    cyc(3);
    rd(`IDX_FLAGS_0, 32'h1 << 7);
    wr(`IDX_FLAGS_0, 32'h1 << 7);
    // Random pulse sources with pins enabled
    r = $urandom;
    wr(`IDX_PULSE_MODE, {23'h0, r[8:0]});
    pin_dis = 1'b0;
    cyc(1);
    check({src3, src2, src1}, r[8:0]);
    rd(`IDX_PULSE_MODE, {23'h0, r[8:0]});
    event_round(15);
    // Second flag register
    wr(`IDX_ENABLE_1, 32'h0300_0000);
    @(posedge clk) volt_peak_end <= 1'b1;
    @(posedge clk) volt_peak_end <= 1'b0;
    cyc(3);
    check(irq_n, 1'b0);
    rd(`IDX_FLAGS_1, 32'h1 << `BIT_VOLT_PEAK);
    wr(`IDX_FLAGS_1, 32'h1 << `BIT_VOLT_PEAK);
    r = $urandom;
    @(posedge clk) begin
      crc_now <= r;
      run_set <= 1'b1;
    end
    @(posedge clk) run_set <= 1'b0;
    @(posedge clk) crc_valid <= 1'b1;
    @(posedge clk) crc_valid <= 1'b0;
    cyc(3);
    rd(`IDX_FLAGS_1, 32'h0000_0000);
    @(posedge clk) begin
      crc_now <= r ^ 32'h0000_0001;
      crc_valid <= 1'b1;
    end
    @(posedge clk) crc_valid <= 1'b0;
    cyc(3);
    check(irq_n, 1'b0);
    rd(`IDX_FLAGS_1, 32'h1 << `BIT_CRC_DIFF);
    wr(`IDX_FLAGS_1, 32'h1 << `BIT_CRC_DIFF);
    cyc(2);
    check(irq_n, 1'b1);
    cyc(4);
    give_verdict();
  end

  initial begin
    #(40 * 20000);
    bad_count++;
    give_verdict();
  end
endmodule

`default_nettype wire

//--- logic/level_change.sv
`timescale 1ns/1ns
`default_nettype none

module level_change #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] level, // Levels to watch
  output logic [WIDTH-1:0] changed, // Pulse on any edge
  output logic [WIDTH-1:0] fell // Pulse on a falling edge
);

  logic [WIDTH-1:0] prev_q;
  logic armed_q;

  // No events in the first cycle after reset, prev_q is not yet valid
  always_ff @(posedge clk) begin
    if (srst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= '0;
    end else begin
      prev_q <= level;
    end
  end

  assign changed = armed_q ? (level ^ prev_q) : '0;
  assign fell = armed_q ? (prev_q & ~level) : '0;

endmodule

`default_nettype wire

//--- logic/meter_irq_status_mask.sv
`timescale 1ns/1ns
`default_nettype none

`include "meter_irq_cfg.svh"

module meter_irq_status_mask
  import meter_irq_pkg::*;
(
  input wire logic clk, // 25 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic hsel, // AHB-Lite select
  input wire logic [31:0] haddr, // AHB-Lite address
  input wire logic [1:0] htrans, // AHB-Lite transfer type
  input wire logic hwrite, // AHB-Lite write
  input wire logic [2:0] hsize, // AHB-Lite size, word only
  input wire logic [31:0] hwdata, // AHB-Lite write data
  input wire logic hready, // AHB-Lite bus ready
  output logic [31:0] hrdata, // AHB-Lite read data
  output logic hreadyout, // AHB-Lite slave ready
  output logic hresp, // AHB-Lite response, always OKAY
  input wire logic [2:0] tot_act_b30, // Bit 30 of total active energy
  input wire logic [2:0] fund_act_b30, // Bit 30 of fund active energy
  input wire logic [2:0] fund_var_b30, // Bit 30 of fund reactive energy
  input wire logic [2:0] apparent_b30, // Bit 30 of apparent energy
  input wire logic line_mode_on, // Line cycle accumulation active
  input wire logic line_cycle_end, // Pulse: half cycle count reached
  input wire logic [2:0] tot_act_neg, // Sign of total active power
  input wire logic [2:0] fund_act_neg, // Sign of fund active power
  input wire logic path1_sum_neg, // Sign of path one power sum
  input wire logic path2_sum_neg, // Sign of path two power sum
  input wire logic [2:0] fund_var_neg, // Sign of fund reactive power
  input wire logic [2:0] pulse_raw_n, // Pulse generator outputs
  input wire logic dsp_cycle_end, // Pulse: periodic DSP pass done
  input wire logic volt_peak_end, // Pulse: voltage peak period over
  input wire logic run_set, // Pulse: run register written one
  input wire logic [31:0] crc_now, // Freshly computed checksum
  input wire logic crc_valid, // Pulse: crc_now is new
  output logic irq_n, // Interrupt request, active low
  output logic [2:0] pulse_pin_n, // Pulse pins after disable
  output logic [2:0] pulse_1_source, // Power source of pulse 1
  output logic [2:0] pulse_2_source, // Power source of pulse 2
  output logic [2:0] pulse_3_source, // Power source of pulse 3
  output logic power_sign_source_sel // 1: fundamental power signs
);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  bus_state_t state_q;
  reg_id_t dp_idx_q;
  logic accept;
  logic wr_en;
  logic [31:0] hrdata_q;
  logic [31:0] en0_q;
  logic [31:0] fl0_q;
  logic [1:0] fl1_q;
  logic [1:0] en1_q;
  logic sign_sel_q;
  logic [11:0] pmode_q;
  logic [31:0] ev0;
  logic [1:0] ev1;
  logic irq_any;
  logic irq_n_q;
  logic [2:0] pin_q;

  function automatic reg_id_t decode(input logic [31:0] addr);
    reg_id_t id;
    id = REG_NONE;
    if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
      case (addr[17:2])
        `IDX_ENABLE_0: id = REG_EN0;
        `IDX_FLAGS_0: id = REG_FL0;
        `IDX_FLAGS_1: id = REG_FL1;
        `IDX_ENABLE_1: id = REG_EN1;
        `IDX_ACC_MODE: id = REG_ACC;
        `IDX_PULSE_MODE: id = REG_PMODE;
        default: id = REG_NONE;
      endcase
    end
    return id;
  endfunction

  assign accept = hsel && hready && htrans[1];
  assign wr_en = (state_q == BUS_WRITE);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= BUS_IDLE;
    end else begin
      case (state_q)
        BUS_RD_WAIT: state_q <= BUS_RD_DONE;
        BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
          if (accept) begin
            state_q <= hwrite ? BUS_WRITE : BUS_RD_WAIT;
          end else begin
            state_q <= BUS_IDLE;
          end
        end
        default: state_q <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dp_idx_q <= REG_NONE;
    end else if (accept) begin
      dp_idx_q <= decode(haddr);
    end
  end

  // Read data is fetched in a wait cycle so a preceding write is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_q <= `RST_RDATA;
    end else if (state_q == BUS_RD_WAIT) begin
      case (dp_idx_q)
        REG_EN0: hrdata_q <= en0_q;
        REG_FL0: hrdata_q <= fl0_q;
        REG_FL1: hrdata_q <= {6'h00, fl1_q, 24'h00_0000};
        REG_EN1: hrdata_q <= {6'h00, en1_q, 24'h00_0000};
        REG_ACC: hrdata_q <= 32'(sign_sel_q) << `BIT_SIGN_SRC_SEL;
        REG_PMODE: hrdata_q <= {20'h0_0000, pmode_q};
        default: hrdata_q <= `RST_RDATA;
      endcase
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = (state_q != BUS_RD_WAIT);
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clk) begin
    if (srst) begin
      en0_q <= `RST_ENABLE_0;
    end else if (wr_en && dp_idx_q == REG_EN0) begin
      en0_q <= hwdata & `FLAGS_0_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      en1_q <= `RST_ENABLE_1;
    end else if (wr_en && dp_idx_q == REG_EN1) begin
      en1_q <= hwdata[`BIT_CRC_DIFF:`BIT_VOLT_PEAK];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sign_sel_q <= `RST_ACC_SEL;
    end else if (wr_en && dp_idx_q == REG_ACC) begin
      sign_sel_q <= hwdata[`BIT_SIGN_SRC_SEL];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pmode_q <= `RST_PULSE_MODE;
    end else if (wr_en && dp_idx_q == REG_PMODE) begin
      pmode_q <= hwdata[`PM_WIDTH-1:0];
    end
  end

  assign pulse_1_source = pmode_q[`PM_SRC1_LSB +: 3];
  assign pulse_2_source = pmode_q[`PM_SRC2_LSB +: 3];
  assign pulse_3_source = pmode_q[`PM_SRC3_LSB +: 3];
  assign power_sign_source_sel = sign_sel_q;

  ////////////////////////////////////////////////////////////////////////
  // Event detection

  logic [2:0] sel_neg;
  logic [22:0] levels;
  logic [22:0] chg;
  logic [22:0] fell;

  assign sel_neg = sign_sel_q ? fund_act_neg : tot_act_neg;
  assign levels = {pulse_raw_n, path2_sum_neg, fund_var_neg,
                   path1_sum_neg, sel_neg, apparent_b30, fund_var_b30,
                   fund_act_b30, tot_act_b30};

  level_change #(
    .WIDTH(23)
  ) u_change (
    .clk(clk),
    .srst(srst),
    .level(levels),
    .changed(chg),
    .fell(fell)
  );

  always_comb begin
    ev0 = 32'h0000_0000;
    ev0[`BIT_TOT_ACT_HALF] = |chg[2:0];
    ev0[`BIT_FUND_ACT_HALF] = |chg[5:3];
    ev0[`BIT_FUND_VAR_HALF] = |chg[8:6];
    ev0[`BIT_APPARENT_HALF] = |chg[11:9];
    ev0[`BIT_LINE_DONE] = line_cycle_end && line_mode_on;
    ev0[`BIT_PHASE_SIGN_LSB +: 3] = chg[14:12];
    ev0[`BIT_PATH1_SIGN] = chg[15];
    ev0[`BIT_VAR_SIGN_LSB +: 3] = chg[18:16];
    ev0[`BIT_PATH2_SIGN] = chg[19];
    // Taken before the pin disable gate
    ev0[`BIT_PULSE_LSB +: 3] = fell[22:20];
    ev0[`BIT_DSP_DONE] = dsp_cycle_end;
  end

  // Checksum reference is captured when the run register is set
  logic [31:0] crc_ref_q;
  logic crc_ref_ok_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      crc_ref_q <= 32'h0000_0000;
      crc_ref_ok_q <= 1'b0;
    end else if (run_set) begin
      crc_ref_q <= crc_now;
      crc_ref_ok_q <= 1'b1;
    end
  end

  assign ev1[0] = volt_peak_end;
  assign ev1[1] = crc_valid && crc_ref_ok_q && !run_set &&
                  (crc_now != crc_ref_q);

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags, write one to clear, a new event wins over the clear

  always_ff @(posedge clk) begin
    if (srst) begin
      fl0_q <= `RST_FLAGS_0;
    end else if (wr_en && dp_idx_q == REG_FL0) begin
      fl0_q <= ((fl0_q & ~hwdata) | ev0) & `FLAGS_0_MASK;
    end else begin
      fl0_q <= (fl0_q | ev0) & `FLAGS_0_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fl1_q <= `RST_FLAGS_1;
    end else if (wr_en && dp_idx_q == REG_FL1) begin
      fl1_q <= (fl1_q & ~hwdata[`BIT_CRC_DIFF:`BIT_VOLT_PEAK]) | ev1;
    end else begin
      fl1_q <= fl1_q | ev1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt and pulse pins

  assign irq_any = |(fl0_q & en0_q) || |(fl1_q & en1_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !irq_any;
    end
  end

  assign irq_n = irq_n_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_q <= 3'h7;
    end else begin
      pin_q <= pulse_raw_n | pmode_q[`PM_DIS_LSB +: 3];
    end
  end

  assign pulse_pin_n = pin_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_write(reg_id_t id);
    state_q == BUS_WRITE && dp_idx_q == id;
  endsequence

  sequence s_read(reg_id_t id);
    state_q == BUS_RD_WAIT && dp_idx_q == id;
  endsequence

  property p_peak_flag;
    volt_peak_end |=> fl1_q[0];
  endproperty
  a_peak_flag: assert property (p_peak_flag)
    else $error("voltage peak flag not set");

  property p_crc_flag;
    crc_valid && crc_ref_ok_q && !run_set && crc_now != crc_ref_q
      |=> fl1_q[1];
  endproperty
  a_crc_flag: assert property (p_crc_flag)
    else $error("checksum mismatch flag not set");

  property p_fl1_reserved;
    s_read(REG_FL1) ##1 1'b1 |-> hreadyout && hrdata[31:26] == 6'h00;
  endproperty
  a_fl1_reserved: assert property (p_fl1_reserved)
    else $error("reserved flag bits not zero");

  property p_tot_half;
    $changed(tot_act_b30) && !$past(srst) |=> fl0_q[0];
  endproperty
  a_tot_half: assert property (p_tot_half)
    else $error("total active half flag missed");

  property p_fund_half;
    $changed(fund_act_b30) && !$past(srst) |=> fl0_q[1];
  endproperty
  a_fund_half: assert property (p_fund_half)
    else $error("fundamental active half flag missed");

  property p_bit2_dead;
    fl0_q[2] == 1'b0 && en0_q[2] == 1'b0;
  endproperty
  a_bit2_dead: assert property (p_bit2_dead)
    else $error("reserved enable bit 2 active");

  property p_line_done;
    line_cycle_end && !line_mode_on && !fl0_q[5] |=> !fl0_q[5];
  endproperty
  a_line_done: assert property (p_line_done)
    else $error("line flag set outside line mode");

  property p_pulse_fall;
    $fell(pulse_raw_n[0]) && !$past(srst) |=> fl0_q[14];
  endproperty
  a_pulse_fall: assert property (p_pulse_fall)
    else $error("pulse one falling edge missed");

  property p_pin_disabled;
    pmode_q[`PM_DIS_LSB] |=> pulse_pin_n[0];
  endproperty
  a_pin_disabled: assert property (p_pin_disabled)
    else $error("disabled pulse pin driven low");

  property p_source_write;
    s_write(REG_PMODE) |=> pulse_2_source == $past(hwdata[5:3]);
  endproperty
  a_source_write: assert property (p_source_write)
    else $error("pulse source not updated");

  property p_dsp_done;
    dsp_cycle_end |=> fl0_q[17];
  endproperty
  a_dsp_done: assert property (p_dsp_done)
    else $error("dsp done flag missed");

  property p_irq_level;
    !$past(srst) |-> irq_n == !$past(irq_any);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output wrong");

  property p_w1c;
    s_write(REG_FL0) ##0 (hwdata[17] && !dsp_cycle_end) |=> !fl0_q[17];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag not cleared by write one");

endmodule

`default_nettype wire

//--- shared/meter_irq_cfg.svh
`ifndef METER_IRQ_CFG_SVH
`define METER_IRQ_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_ENABLE_0 16'hE50A
`define IDX_FLAGS_0 16'hE600
`define IDX_FLAGS_1 16'hE601
`define IDX_ENABLE_1 16'hE602
`define IDX_ACC_MODE 16'hE603
`define IDX_PULSE_MODE 16'hE604

// Reset values
`define RST_ENABLE_0 32'h0000_0000
`define RST_FLAGS_0 32'h0000_0000
`define RST_FLAGS_1 2'h0
`define RST_ENABLE_1 2'h0
`define RST_ACC_SEL 1'h0
`define RST_PULSE_MODE 12'h000
`define RST_RDATA 32'h0000_0000

// Implemented bits of the first flag and enable registers
`define FLAGS_0_MASK 32'h0003_FFFB

// First flag and enable register bit positions
`define BIT_TOT_ACT_HALF 0
`define BIT_FUND_ACT_HALF 1
`define BIT_FUND_VAR_HALF 3
`define BIT_APPARENT_HALF 4
`define BIT_LINE_DONE 5
`define BIT_PHASE_SIGN_LSB 6
`define BIT_PATH1_SIGN 9
`define BIT_VAR_SIGN_LSB 10
`define BIT_PATH2_SIGN 13
`define BIT_PULSE_LSB 14
`define BIT_DSP_DONE 17

// Second flag register: upper flags
`define BIT_VOLT_PEAK 24
`define BIT_CRC_DIFF 25
`define FLAGS_1_LSB 24

// Accumulation mode and pulse mode fields
`define BIT_SIGN_SRC_SEL 6
`define PM_SRC1_LSB 0
`define PM_SRC2_LSB 3
`define PM_SRC3_LSB 6
`define PM_DIS_LSB 9
`define PM_WIDTH 12

`endif

//--- shared/meter_irq_pkg.sv
package meter_irq_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_RD_WAIT = 2'b10,
    BUS_RD_DONE = 2'b11
  } bus_state_t;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_EN0 = 3'b001,
    REG_FL0 = 3'b010,
    REG_FL1 = 3'b011,
    REG_EN1 = 3'b100,
    REG_ACC = 3'b101,
    REG_PMODE = 3'b110
  } reg_id_t;

endpackage
